/* File: bench/burst_reader_tb.sv */
`timescale 1ns/100ps
module burst_reader_tb;
    logic        mclk, rst_b, reg_wr, reg_rd, burst_enable, burst_start;
    logic        out_ready, clr, stall, out_valid, fifo_pop, burst_active;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, fifo_byte, out_data, d;
    logic [1:0]  status_mode;
    logic [15:0] n_bytes, n_stat1, n_stat2, n_pops;
    int          fails, checks_done;

    burst_reader dut (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .burst_enable(burst_enable), .status_mode(status_mode), .burst_start(burst_start),
        .fifo_byte(fifo_byte), .status1_byte(8'hA1), .status2_byte(8'hB2),
        .fifo_pop(fifo_pop), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .burst_active(burst_active));
    host_sink host (.mclk(mclk), .clr(clr), .stall(stall), .out_data(out_data),
        .out_valid(out_valid), .out_ready(out_ready), .n_bytes(n_bytes),
        .n_stat1(n_stat1), .n_stat2(n_stat2));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (clr) n_pops <= 16'h0000;
        else if (fifo_pop === 1'b1) n_pops <= n_pops + 16'h0001;
    end
    always @(negedge mclk) begin
        if (fifo_pop === 1'b1) fifo_byte <= fifo_byte + 8'h01;
    end

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task reg_write(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
        @(negedge mclk) reg_wr = 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge mclk) reg_rd = 1'b0;
        @(negedge mclk) v = reg_rdata;
    endtask : reg_read
    task run_burst(input logic en, input logic [1:0] m, input logic [7:0] c, input logic s);
        int k, n;
        k = (m == 2'h3) ? 1 : int'(m);
        @(negedge mclk) {clr, burst_enable, status_mode, stall} = {1'b1, en, m, s};
        @(negedge mclk) {clr, burst_start} = 2'b01;
        @(negedge mclk) burst_start = 1'b0;
        for (n = 0; n < 400 && (burst_active === 1'b1 || out_valid === 1'b1); n++)
            @(negedge mclk);
        if (n == 400) fails++;
        check("bytes", n_bytes, en ? 16'(c * (6 + k)) : 16'h0000);
        check("pops", n_pops, en ? 16'(c * 6) : 16'h0000);
        check("status1", n_stat1, (en && k > 0) ? 16'(c) : 16'h0000);
        check("status2", n_stat2, (en && k == 2) ? 16'(c) : 16'h0000);
        $display("burst test done mode %0d count %0d", m, c);
    endtask : run_burst
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial begin
        #40000;
        fails++;
        give_verdict();
    end
    initial begin
        {rst_b, reg_wr, reg_rd, burst_enable, burst_start, clr, stall} = 7'h00;
        {reg_addr, reg_wdata, fifo_byte, status_mode} = 26'h0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        reg_read(burst_pkg::COUNT_ADDR, d);
        check("count reset", 16'(d), 16'(burst_pkg::COUNT_RESET));
        run_burst(1'b1, 2'h0, 8'h06, 1'b0);
        reg_write(burst_pkg::COUNT_ADDR, 8'h00);
        run_burst(1'b0, 2'h0, 8'h00, 1'b0);
        run_burst(1'b1, 2'h0, 8'h00, 1'b0);
        reg_write(burst_pkg::COUNT_ADDR, 8'h03);
        reg_write(8'h4A, 8'h09);
        reg_read(burst_pkg::COUNT_ADDR, d);
        check("count rw", 16'(d), 16'h0003);
        $display("register test done");
        for (int m = 0; m < 4; m++) run_burst(1'b1, 2'(m), 8'h03, m[0]);
        run_burst(1'b0, 2'h2, 8'h03, 1'b0);
        @(negedge mclk) rst_b = 1'b0;
        @(negedge mclk) rst_b = 1'b1;
        reg_read(burst_pkg::COUNT_ADDR, d);
        check("count after reset", 16'(d), 16'(burst_pkg::COUNT_RESET));
        $display("reset test done");
        give_verdict();
    end
endmodule : burst_reader_tb

/* File: bench/host_sink.sv */
`timescale 1ns/100ps
module host_sink (
    input  wire logic        mclk,
    input  wire logic        clr,
    input  wire logic        stall,
    input  wire logic [7:0]  out_data,
    input  wire logic        out_valid,
    output logic             out_ready,
    output logic      [15:0] n_bytes,
    output logic      [15:0] n_stat1,
    output logic      [15:0] n_stat2
);
    initial out_ready = 1'b0;
    // stalls every other cycle when asked
    always @(negedge mclk) begin
        out_ready <= stall ? ~out_ready : 1'b1;
    end
    // counts whole bytes; samples are framed by the device
    always @(posedge mclk) begin
        if (clr) begin
            n_bytes <= 16'h0000;
            n_stat1 <= 16'h0000;
            n_stat2 <= 16'h0000;
        end else if (out_valid === 1'b1 && out_ready) begin
            n_bytes <= n_bytes + 16'h0001;
            n_stat1 <= n_stat1 + 16'(out_data === 8'hA1);
            n_stat2 <= n_stat2 + 16'(out_data === 8'hB2);
        end
    end
endmodule : host_sink

/* File: include/burst_pkg.sv */
package burst_pkg;
    localparam logic [7:0] COUNT_ADDR    = 8'h4B;
    localparam logic [7:0] COUNT_RESET   = 8'h06;
    localparam logic [3:0] DATA_BYTES    = 4'h6;
    localparam logic [1:0] STATUS_NONE   = 2'h0;
    localparam logic [1:0] STATUS_ONE    = 2'h1;
    localparam logic [1:0] STATUS_TWO    = 2'h2;
    localparam logic [2:0] DATA_IDX_LAST = 3'h5;

    typedef enum logic [1:0] {
        SRC_FIFO,
        SRC_STATUS1,
        SRC_STATUS2
    } byte_src_type;
endpackage : burst_pkg

/* File: logic/burst_reader.sv */
`timescale 1ns/100ps
module burst_reader (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       burst_enable,
    input  wire logic [1:0] status_mode,
    input  wire logic       burst_start,
    input  wire logic [7:0] fifo_byte,
    input  wire logic [7:0] status1_byte,
    input  wire logic [7:0] status2_byte,
    output logic            fifo_pop,
    output logic      [7:0] out_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic            burst_active
);
    // whole state of the reader, registered as one record
    typedef struct packed {
        logic [7:0]              count_reg;
        logic                    active_reg;
        logic [7:0]              samples_left_reg;
        logic [2:0]              data_idx_reg;
        burst_pkg::byte_src_type src_reg;
        logic [1:0]              status_mode_reg;
        logic [1:0][7:0]         buf_reg;
        logic [1:0]              buf_fill_reg;
        logic                    pop_reg;
        logic [7:0]              rdata_reg;
        logic                    valid_reg;
        logic [10:0]             produced_reg;
    } state_type;

    state_type st_reg;
    state_type st_next;

    function automatic logic [7:0] pick(input burst_pkg::byte_src_type s,
                                        input logic [7:0] f, input logic [7:0] a,
                                        input logic [7:0] b);
        case (s)
            burst_pkg::SRC_FIFO:    pick = f;
            burst_pkg::SRC_STATUS1: pick = a;
            burst_pkg::SRC_STATUS2: pick = b;
            default:                pick = f;
        endcase
    endfunction : pick

    // bytes in one sample for a status setting; mode 3 behaves as one status byte
    function automatic logic [3:0] bytes_per_sample(input logic [1:0] m);
        case (m)
            burst_pkg::STATUS_NONE: bytes_per_sample = burst_pkg::DATA_BYTES;
            burst_pkg::STATUS_TWO:  bytes_per_sample = burst_pkg::DATA_BYTES + 4'h2;
            default:                bytes_per_sample = burst_pkg::DATA_BYTES + 4'h1;
        endcase
    endfunction : bytes_per_sample

    logic drain;
    logic space;
    logic produce;
    logic last_of_sample;

    always_comb begin
        st_next = st_reg;
        drain   = out_valid && out_ready;
        space   = (st_reg.buf_fill_reg != 2'h2) || drain;
        produce = st_reg.active_reg && space;
        last_of_sample = 1'b0;
        st_next.pop_reg = 1'b0;
        if (reg_wr && reg_addr == burst_pkg::COUNT_ADDR) begin
            st_next.count_reg = reg_wdata;
        end
        st_next.rdata_reg = (reg_rd && reg_addr == burst_pkg::COUNT_ADDR) ?
                            st_reg.count_reg : st_reg.rdata_reg;
        if (drain) begin
            st_next.buf_reg[0] = st_reg.buf_reg[1];
        end
        if (!st_reg.active_reg && burst_start && burst_enable
            && st_reg.count_reg != 8'h00) begin
            // count only consulted when burst mode is on
            st_next.active_reg       = 1'b1;
            st_next.samples_left_reg = st_reg.count_reg;
            st_next.data_idx_reg     = 3'h0;
            st_next.src_reg          = burst_pkg::SRC_FIFO;
            st_next.status_mode_reg  = status_mode;
        end
        if (produce) begin
            if (drain && st_reg.buf_fill_reg == 2'h2) begin
                st_next.buf_reg[1] = pick(st_reg.src_reg, fifo_byte, status1_byte,
                                          status2_byte);
            end else if (drain || st_reg.buf_fill_reg == 2'h0) begin
                st_next.buf_reg[0] = pick(st_reg.src_reg, fifo_byte, status1_byte,
                                          status2_byte);
            end else begin
                st_next.buf_reg[1] = pick(st_reg.src_reg, fifo_byte, status1_byte,
                                          status2_byte);
            end
            case (st_reg.src_reg)
                burst_pkg::SRC_FIFO: begin
                    st_next.pop_reg      = 1'b1;
                    st_next.data_idx_reg = st_reg.data_idx_reg + 3'h1;
                    if (st_reg.data_idx_reg == burst_pkg::DATA_IDX_LAST) begin
                        st_next.data_idx_reg = 3'h0;
                        if (st_reg.status_mode_reg == burst_pkg::STATUS_NONE) begin
                            last_of_sample = 1'b1;
                        end else begin
                            st_next.src_reg = burst_pkg::SRC_STATUS1;
                        end
                    end
                end
                burst_pkg::SRC_STATUS1: begin
                    if (st_reg.status_mode_reg == burst_pkg::STATUS_TWO) begin
                        st_next.src_reg = burst_pkg::SRC_STATUS2;
                    end else begin
                        st_next.src_reg = burst_pkg::SRC_FIFO;
                        last_of_sample  = 1'b1;
                    end
                end
                burst_pkg::SRC_STATUS2: begin
                    st_next.src_reg = burst_pkg::SRC_FIFO;
                    last_of_sample  = 1'b1;
                end
                default: begin
                    st_next.src_reg = burst_pkg::SRC_FIFO;
                end
            endcase
            if (last_of_sample) begin
                st_next.samples_left_reg = st_reg.samples_left_reg - 8'h01;
                if (st_reg.samples_left_reg == 8'h01) begin
                    st_next.active_reg = 1'b0;
                end
            end
        end
        st_next.buf_fill_reg = st_reg.buf_fill_reg + {1'b0, produce} - {1'b0, drain};
        st_next.valid_reg    = st_next.buf_fill_reg != 2'h0;
        // bytes produced in the current burst, for the length check
        if (!st_reg.active_reg) begin
            st_next.produced_reg = 11'h000;
        end else if (produce) begin
            st_next.produced_reg = st_reg.produced_reg + 11'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg           <= '0;
            st_reg.count_reg <= burst_pkg::COUNT_RESET;
            st_reg.src_reg   <= burst_pkg::SRC_FIFO;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata    = st_reg.rdata_reg;
    assign fifo_pop     = st_reg.pop_reg;
    assign out_data     = st_reg.buf_reg[0];
    assign out_valid    = st_reg.valid_reg;
    assign burst_active = st_reg.active_reg;

    AST_RESET_COUNT: assert property (@(posedge mclk)
        $rose(rst_b) |-> st_reg.count_reg == burst_pkg::COUNT_RESET)
        else $error("count not at reset value");
    AST_WRITE_COUNT: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_wr && reg_addr == burst_pkg::COUNT_ADDR |=> st_reg.count_reg == $past(reg_wdata))
        else $error("count write lost");
    AST_READ_COUNT: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_rd && reg_addr == burst_pkg::COUNT_ADDR && !reg_wr
        |=> reg_rdata == st_reg.count_reg)
        else $error("count readback wrong");
    AST_NO_BURST_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
        !st_reg.active_reg && !burst_enable |=> !st_reg.active_reg)
        else $error("burst started while disabled");
    AST_START_LOAD: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(st_reg.active_reg) |-> st_reg.samples_left_reg == $past(st_reg.count_reg))
        else $error("burst length not loaded");
    AST_SAMPLE_SIX: assert property (@(posedge mclk) disable iff (!rst_b)
        produce && st_reg.src_reg != burst_pkg::SRC_FIFO
        |-> st_reg.data_idx_reg == 3'h0)
        else $error("status byte before six data bytes");
    AST_END_LEN: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(st_reg.active_reg) |-> $past(st_reg.produced_reg) + 11'h001 ==
        11'({3'h0, st_reg.count_reg} * {7'h00, bytes_per_sample(st_reg.status_mode_reg)}))
        else $error("burst ended at wrong byte");
    AST_VALID_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
        out_valid && !out_ready |=> out_valid && out_data == $past(out_data))
        else $error("stalled byte changed");
    AST_POP_ON_DATA: assert property (@(posedge mclk) disable iff (!rst_b)
        produce && st_reg.src_reg == burst_pkg::SRC_FIFO |=> fifo_pop)
        else $error("data byte not popped");
    AST_NO_POP_STATUS: assert property (@(posedge mclk) disable iff (!rst_b)
        produce && st_reg.src_reg != burst_pkg::SRC_FIFO |=> !fifo_pop)
        else $error("status byte popped the fifo");
    AST_IDLE_NO_POP: assert property (@(posedge mclk) disable iff (!rst_b)
        !st_reg.active_reg |=> !fifo_pop)
        else $error("pop outside a burst");
    AST_ZERO_NO_START: assert property (@(posedge mclk) disable iff (!rst_b)
        !st_reg.active_reg && st_reg.count_reg == 8'h00 |=> !st_reg.active_reg)
        else $error("burst started with zero count");
    AST_START_ANSWER: assert property (@(posedge mclk) disable iff (!rst_b)
        !st_reg.active_reg && burst_start && burst_enable && st_reg.count_reg != 8'h00
        |=> burst_active)
        else $error("burst request not taken");
    AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_STATUS_ONE_END: assert property (@(posedge mclk) disable iff (!rst_b)
        produce && st_reg.src_reg == burst_pkg::SRC_STATUS1
        && st_reg.status_mode_reg != burst_pkg::STATUS_TWO
        |=> st_reg.src_reg == burst_pkg::SRC_FIFO)
        else $error("extra status byte");
    AST_STATUS_TWO: assert property (@(posedge mclk) disable iff (!rst_b)
        produce && st_reg.src_reg == burst_pkg::SRC_STATUS1
        && st_reg.status_mode_reg == burst_pkg::STATUS_TWO
        |=> st_reg.src_reg == burst_pkg::SRC_STATUS2)
        else $error("second status byte missing");
    AST_INDEX_RANGE: assert property (@(posedge mclk) disable iff (!rst_b)
        st_reg.data_idx_reg <= burst_pkg::DATA_IDX_LAST)
        else $error("data index past last byte");
    AST_FILL_RANGE: assert property (@(posedge mclk) disable iff (!rst_b)
        st_reg.buf_fill_reg != 2'h3)
        else $error("buffer fill out of range");
    AST_SAMPLES_LEFT: assert property (@(posedge mclk) disable iff (!rst_b)
        st_reg.active_reg |-> st_reg.samples_left_reg != 8'h00)
        else $error("burst active with no samples left");
    AST_NO_OVERFLOW: assert property (@(posedge mclk) disable iff (!rst_b)
        st_reg.buf_fill_reg == 2'h2 && !out_ready |=> st_reg.buf_fill_reg == 2'h2)
        else $error("buffer lost a byte");
endmodule : burst_reader
